// ==== hw/mcs_consts.svh ====
// Offsets, field positions, reset values and counts of the settings block
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH
`define MCS_OFF_CTRL 8'h00
`define MCS_OFF_EVMASK 8'h04
`define MCS_OFF_EVENT 8'h08
`define MCS_OFF_STATUS 8'h0c
`define MCS_OFF_CH_A 4'h1
`define MCS_OFF_CH_B 4'h2
`define MCS_OFF_PAIR0 8'h30
`define MCS_OFF_PAIR1 8'h34
`define MCS_CH_CFG 2'h0
`define MCS_CH_WAVE 2'h1
`define MCS_CH_RANGE 2'h2
`define MCS_CH_DATA 2'h3
`define MCS_CTRL_TRIG_EN 0
`define MCS_CTRL_EDGE 1
`define MCS_CTRL_LOCK 2
`define MCS_EV_FILT 0
`define MCS_EV_REF 1
`define MCS_ST_NEW_VALID_DATA_FLAG 0
`define MCS_ST_DEV_ERR 3
`define MCS_ST_COUNT 4
`define MCS_CFG_FILT 0
`define MCS_CFG_MODE 4
`define MCS_CFG_REF 8
`define MCS_CFG_UNITS 12
`define MCS_CFG_DUNITS 16
`define MCS_RNG_GAIN 0
`define MCS_RNG_AUTO 8
`define MCS_RST_TRIG_EN 1'h0
`define MCS_RST_EDGE 1'h1
`define MCS_RST_LOCK 1'h0
`define MCS_RST_MASK 8'h00
`define MCS_RST_FILT 2'h0
`define MCS_RST_WAVE 16'h0000
`define MCS_RST_GAIN 4'h0
`define MCS_RST_AUTO 1'h1
`define MCS_UNITS_PWR 3'h0
`define MCS_UNITS_NRG 3'h4
`define MCS_UNITS_NRG_BIT 2
`define MCS_MODE_BAD 3'h7
`define MCS_REF_BAD 2'h3
`define MCS_STAT_OK 3'h0
`define MCS_AVG_HIST 9
`endif

// ==== hw/mcs_pkg.sv ====
// Types shared by the settings block
package mcs_pkg;
  typedef enum logic [2:0] {
    dc_single_mode,
    dc_continuous_mode,
    integration_mode,
    peak_peak_single_mode,
    peak_peak_continuous_mode,
    one_pulse_mode,
    repeated_pulse_mode
  } mcs_mode_e;
  typedef enum logic [1:0] {
    stored_reference_source,
    other_channel_source,
    user_value_source
  } mcs_ref_e;
  typedef enum logic [1:0] {
    det_low_power,
    det_high_power,
    det_energy
  } mcs_det_e;
endpackage

// ==== hw/mcs_avg.sv ====
// Ten-reading running averager for one channel
`timescale 1ns/1ps
`default_nettype none
`include "mcs_consts.svh"
module mcs_avg (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic clr,
  input wire logic en,
  // Reading in
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  // Result
  output logic out_valid,
  output logic [31:0] out_data
);
  logic [31:0] hist_q [`MCS_AVG_HIST];
  logic [3:0] count_q;
  logic [35:0] sum_q;
  logic [35:0] sum_all;
  logic [35:0] avg;
  logic full;

  // Until the history fills, divide by the readings actually held
  assign full = count_q == 4'(`MCS_AVG_HIST);
  assign sum_all = sum_q + {4'h0, in_data};
  assign avg = sum_all / {32'h0, count_q + 4'h1};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `MCS_AVG_HIST; i++) begin
        hist_q[i] <= 32'h0;
      end
      count_q <= 4'h0;
      sum_q <= 36'h0;
    end else if (clr) begin
      count_q <= 4'h0;
      sum_q <= 36'h0;
    end else if (in_valid && en) begin
      hist_q[0] <= in_data;
      for (int i = 1; i < `MCS_AVG_HIST; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
      sum_q <= full ? sum_all - {4'h0, hist_q[`MCS_AVG_HIST-1]} : sum_all;
      count_q <= full ? count_q : count_q + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'h0;
      out_data <= 32'h0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= en ? avg[31:0] : in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/mcs_top.sv ====
// Two-channel meter settings and readout control, AHB-Lite slave
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_consts.svh"
module mcs_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output wire logic hreadyout,
  output wire logic hresp,
  // External trigger
  input wire logic trig_in,
  output logic trig_pulse,
  // Readings from acquisition
  input wire logic [1:0] meas_valid,
  input wire logic [1:0][2:0] meas_status,
  input wire logic [1:0][31:0] meas_value,
  // Detector and front end state
  input wire logic [1:0][1:0] det_type,
  input wire logic [1:0] ch_avail,
  input wire logic [1:0] ch_acquiring,
  input wire logic [1:0][15:0] cal_point_nm,
  input wire logic [1:0][3:0] gain_in_use,
  // Global settings
  output wire logic trig_enable,
  output wire logic trig_rising,
  output wire logic front_panel_lockout,
  output wire logic device_error,
  // Per-channel settings and flags
  output wire logic [1:0] analog_lpf_sel,
  output wire logic [1:0][2:0] mode_sel,
  output wire logic [1:0][2:0] units_sel,
  output wire logic [1:0][1:0] ref_sel,
  output wire logic [1:0][15:0] wavelength_nm,
  output wire logic [1:0][3:0] manual_gain,
  output wire logic [1:0] auto_range,
  output wire logic [1:0] new_valid_data_flag
);
  // Bus state
  logic wr_q, rd_q, rd_done_q;
  logic [7:0] addr_q;
  logic addr_phase;
  logic rd_cap;
  logic [31:0] rd_mux;

  // Global registers
  logic trig_en_q, edge_q, lock_q;
  logic [7:0] evmask_q;
  logic [7:0] event_q;
  logic [31:0] second_q;
  logic sync1_q, sync2_q, sync3_q;

  // Decode
  logic sel_ctrl, sel_mask, sel_ev, sel_st, sel_p0, sel_p1;
  logic [1:0] ch_hit;
  logic [1:0] ch_word;
  logic two, first_ch;
  logic [1:0] pair_clr;
  logic [7:0] ev_set;
  logic [1:0][31:0] ch_rd;
  logic [1:0][31:0] ch_val;
  logic [1:0] ev_filt, ev_ref;
  logic [31:0] ctrl_rd, st_rd;
  logic edge_rise, edge_fall;

  function automatic logic is_pp(input logic [2:0] m);
    is_pp = m == mcs_pkg::peak_peak_single_mode || m == mcs_pkg::peak_peak_continuous_mode;
  endfunction

  function automatic logic is_nrg(input logic [2:0] m);
    is_nrg = m == mcs_pkg::integration_mode || m == mcs_pkg::one_pulse_mode ||
      m == mcs_pkg::repeated_pulse_mode;
  endfunction

  // Reads take one wait state so a write just before is always seen
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_cap = rd_q & ~rd_done_q;
  assign hreadyout = ~rd_cap;
  assign hresp = 1'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= addr_phase & hwrite & (haddr[31:8] == 24'h0);
      rd_q <= addr_phase & ~hwrite;
      addr_q <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_q <= 1'h0;
      hrdata <= 32'h0;
    end else begin
      rd_done_q <= rd_cap;
      if (rd_cap) begin
        hrdata <= rd_mux;
      end
    end
  end

  assign sel_ctrl = addr_q == `MCS_OFF_CTRL;
  assign sel_mask = addr_q == `MCS_OFF_EVMASK;
  assign sel_ev = addr_q == `MCS_OFF_EVENT;
  assign sel_st = addr_q == `MCS_OFF_STATUS;
  assign sel_p0 = addr_q == `MCS_OFF_PAIR0;
  assign sel_p1 = addr_q == `MCS_OFF_PAIR1;
  assign ch_hit[0] = addr_q[7:4] == `MCS_OFF_CH_A;
  assign ch_hit[1] = addr_q[7:4] == `MCS_OFF_CH_B;
  assign ch_word = addr_q[3:2];

  // Global settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_en_q <= `MCS_RST_TRIG_EN;
      edge_q <= `MCS_RST_EDGE;
      lock_q <= `MCS_RST_LOCK;
    end else if (wr_q && sel_ctrl) begin
      trig_en_q <= hwdata[`MCS_CTRL_TRIG_EN];
      edge_q <= hwdata[`MCS_CTRL_EDGE];
      lock_q <= hwdata[`MCS_CTRL_LOCK];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evmask_q <= `MCS_RST_MASK;
    end else if (wr_q && sel_mask) begin
      evmask_q <= hwdata[7:0];
    end
  end

  // Event bits are sticky; a refusal in the clearing read cycle is kept
  assign ev_set = (8'(|ev_filt) << `MCS_EV_FILT) | (8'(|ev_ref) << `MCS_EV_REF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_q <= 8'h00;
    end else begin
      event_q <= ((rd_cap && sel_ev) ? 8'h00 : event_q) | ev_set;
    end
  end

  assign device_error = |(event_q & evmask_q);

  // Trigger path, sync1_q feeds only sync2_q
  assign edge_rise = sync2_q & ~sync3_q;
  assign edge_fall = ~sync2_q & sync3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
      sync3_q <= 1'h0;
      trig_pulse <= 1'h0;
    end else begin
      sync1_q <= trig_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      trig_pulse <= trig_en_q & (edge_q ? edge_rise : edge_fall);
    end
  end

  assign trig_enable = trig_en_q;
  assign trig_rising = edge_q;
  assign front_panel_lockout = lock_q;

  // Pair read: first value now, second held for the next word
  assign two = &ch_acquiring;
  assign first_ch = ~two & ch_acquiring[1];
  assign pair_clr = (rd_cap && sel_p0) ? (two ? 2'h3 : (first_ch ? 2'h2 : 2'h1)) : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_q <= 32'h0;
    end else if (rd_cap && sel_p0) begin
      second_q <= two ? ch_val[1] : 32'h0;
    end
  end

  assign ctrl_rd = (32'(trig_en_q) << `MCS_CTRL_TRIG_EN) | (32'(edge_q) << `MCS_CTRL_EDGE) |
    (32'(lock_q) << `MCS_CTRL_LOCK);
  assign st_rd = (32'(new_valid_data_flag) << `MCS_ST_NEW_VALID_DATA_FLAG) |
    (32'(device_error) << `MCS_ST_DEV_ERR) | (32'(two ? 2'h2 : 2'h1) << `MCS_ST_COUNT);

  assign rd_mux = sel_ctrl ? ctrl_rd :
    sel_mask ? {24'h0, evmask_q} :
    sel_ev ? {24'h0, event_q} :
    sel_st ? st_rd :
    ch_hit[0] ? ch_rd[0] :
    ch_hit[1] ? ch_rd[1] :
    sel_p0 ? ch_val[first_ch] :
    sel_p1 ? second_q : 32'h0;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0] filt_q;
    mcs_pkg::mcs_mode_e mode_q;
    mcs_pkg::mcs_ref_e ref_q;
    logic [2:0] units_q;
    logic [2:0] vunits_q;
    logic [15:0] wave_q;
    logic [3:0] gain_q;
    logic auto_q;
    logic new_valid_data_flag_q;
    logic [31:0] val_q;
    logic cfg_wr, wav_wr, rng_wr, clr_flag;
    logic low_pwr, filt_bad, mode_bad, ref_bad, nrg, in_ok, avg_v;
    logic [31:0] avg_d;
    logic [1:0] req_filt;
    logic [1:0] req_ref;
    logic [2:0] req_mode;
    logic [2:0] req_units;
    logic [2:0] mode_d;
    logic [1:0] filt_d;
    logic [1:0] filt_rd;
    logic [31:0] cfg_rd;

    assign cfg_wr = wr_q & ch_hit[c] & (ch_word == `MCS_CH_CFG);
    assign wav_wr = wr_q & ch_hit[c] & (ch_word == `MCS_CH_WAVE);
    assign rng_wr = wr_q & ch_hit[c] & (ch_word == `MCS_CH_RANGE);
    assign clr_flag = (rd_cap & ch_hit[c] & (ch_word == `MCS_CH_DATA)) | pair_clr[c];

    assign req_filt = hwdata[`MCS_CFG_FILT +: 2];
    assign req_mode = hwdata[`MCS_CFG_MODE +: 3];
    assign req_ref = hwdata[`MCS_CFG_REF +: 2];
    assign req_units = hwdata[`MCS_CFG_UNITS +: 3];
    assign low_pwr = det_type[c] == mcs_pkg::det_low_power;

    assign mode_bad = req_mode == `MCS_MODE_BAD;
    assign mode_d = mode_bad ? mode_q : req_mode;
    assign filt_bad = req_filt[0] & ~(low_pwr & ~is_pp(mode_d));
    assign filt_d = filt_bad ? filt_q : req_filt;
    assign ref_bad = (req_ref == `MCS_REF_BAD) ||
      (req_ref == mcs_pkg::other_channel_source && !ch_avail[1-c]);
    assign nrg = is_nrg(mode_d);
    assign ev_filt[c] = cfg_wr & (filt_bad | mode_bad);
    assign ev_ref[c] = cfg_wr & ref_bad;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        filt_q <= `MCS_RST_FILT;
        mode_q <= mcs_pkg::dc_single_mode;
        ref_q <= mcs_pkg::stored_reference_source;
        units_q <= `MCS_UNITS_PWR;
      end else if (cfg_wr) begin
        filt_q <= filt_d;
        mode_q <= mcs_pkg::mcs_mode_e'(mode_d);
        if (!ref_bad) begin
          ref_q <= mcs_pkg::mcs_ref_e'(req_ref);
        end
        // Units follow the mode family when the request does not fit
        units_q <= (req_units[`MCS_UNITS_NRG_BIT] == nrg) ? req_units :
          (nrg ? `MCS_UNITS_NRG : `MCS_UNITS_PWR);
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wave_q <= `MCS_RST_WAVE;
        gain_q <= `MCS_RST_GAIN;
        auto_q <= `MCS_RST_AUTO;
      end else begin
        if (wav_wr) begin
          wave_q <= hwdata[15:0];
        end
        if (rng_wr) begin
          auto_q <= hwdata[`MCS_RNG_AUTO];
          if (!hwdata[`MCS_RNG_AUTO]) begin
            gain_q <= hwdata[`MCS_RNG_GAIN +: 4];
          end
        end
      end
    end

    assign in_ok = meas_valid[c] & (meas_status[c] == `MCS_STAT_OK);

    mcs_avg u_avg (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(cfg_wr && (filt_d != filt_q)),
      .en(filt_q[1]),
      .in_valid(in_ok),
      .in_data(meas_value[c]),
      .out_valid(avg_v),
      .out_data(avg_d)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        val_q <= 32'h0;
        vunits_q <= `MCS_UNITS_PWR;
        new_valid_data_flag_q <= 1'h0;
      end else begin
        if (avg_v) begin
          val_q <= avg_d;
          vunits_q <= units_q;
        end
        new_valid_data_flag_q <= (new_valid_data_flag_q & ~clr_flag) | avg_v;
      end
    end

    // Other detector families never show the analog bit
    assign filt_rd = low_pwr ? filt_q : {filt_q[1], 1'h0};
    assign cfg_rd = (32'(filt_rd) << `MCS_CFG_FILT) | (32'(mode_q) << `MCS_CFG_MODE) |
      (32'(ref_q) << `MCS_CFG_REF) | (32'(units_q) << `MCS_CFG_UNITS) |
      (32'(vunits_q) << `MCS_CFG_DUNITS);
    assign ch_rd[c] = (ch_word == `MCS_CH_CFG) ? cfg_rd :
      (ch_word == `MCS_CH_WAVE) ? {16'h0, cal_point_nm[c]} :
      (ch_word == `MCS_CH_RANGE) ? ((32'(auto_q) << `MCS_RNG_AUTO) |
      (32'(gain_in_use[c]) << `MCS_RNG_GAIN)) : val_q;
    assign ch_val[c] = val_q;

    assign analog_lpf_sel[c] = filt_q[0] & low_pwr & ~is_pp(mode_q);
    assign mode_sel[c] = mode_q;
    assign units_sel[c] = units_q;
    assign ref_sel[c] = ref_q;
    assign wavelength_nm[c] = wave_q;
    assign manual_gain[c] = gain_q;
    assign auto_range[c] = auto_q;
    assign new_valid_data_flag[c] = new_valid_data_flag_q;
  end
endmodule
`default_nettype wire

// ==== sim/mcs_properties.sv ====
// Concurrent checks on the settings block ports
`timescale 1ns/1ps
`default_nettype none
module mcs_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Trigger
  input wire logic trig_in,
  input wire logic trig_pulse,
  input wire logic trig_enable,
  input wire logic trig_rising,
  // Channels
  input wire logic [1:0] meas_valid,
  input wire logic [1:0][2:0] meas_status,
  input wire logic [1:0][1:0] det_type,
  input wire logic [1:0][2:0] mode_sel,
  input wire logic [1:0][2:0] units_sel,
  input wire logic [1:0][1:0] ref_sel,
  input wire logic [1:0] analog_lpf_sel,
  input wire logic [1:0] new_valid_data_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_trig_gate;
    trig_pulse |-> $past(trig_enable);
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("trigger while disabled");
  property p_trig_one;
    trig_pulse |=> !trig_pulse;
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger pulse too long");
  property p_trig_rise;
    $rose(trig_in) && trig_enable && trig_rising |-> ##[1:6] trig_pulse;
  endproperty
  a_trig_rise: assert property (p_trig_rise) else $error("rising edge missed");
  property p_trig_fall;
    $fell(trig_in) && trig_enable && !trig_rising |-> ##[1:6] trig_pulse;
  endproperty
  a_trig_fall: assert property (p_trig_fall) else $error("falling edge missed");
  property p_lpf;
    analog_lpf_sel[0] |-> det_type[0] == 2'h0 && !(mode_sel[0] inside {3'h3, 3'h4});
  endproperty
  a_lpf: assert property (p_lpf) else $error("analog path on bad detector");
  property p_flag_src;
    $rose(new_valid_data_flag[0]) |-> $past(meas_valid[0] && meas_status[0] == 3'h0, 2);
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag without valid reading");
  property p_mode;
    mode_sel[0] != 3'h7 && mode_sel[1] != 3'h7;
  endproperty
  a_mode: assert property (p_mode) else $error("illegal mode held");
  property p_ref;
    ref_sel[0] != 2'h3 && ref_sel[1] != 2'h3;
  endproperty
  a_ref: assert property (p_ref) else $error("illegal reference held");
  property p_units;
    units_sel[0][2] == (mode_sel[0] inside {3'h2, 3'h5, 3'h6});
  endproperty
  a_units: assert property (p_units) else $error("units family mismatch");
  c_trig: cover property (trig_pulse);
  c_flag: cover property ($rose(new_valid_data_flag[0]));
  c_lpf: cover property (analog_lpf_sel[0]);
endmodule
`default_nettype wire

// ==== sim/mcs_frontend_model.sv ====
// Acquisition front end offering readings and detector state
`timescale 1ns/1ps
`default_nettype none
module mcs_frontend_model (
  // Clock
  input wire logic hclk,
  // Readings
  output var logic [1:0] meas_valid,
  output var logic [1:0][2:0] meas_status,
  output var logic [1:0][31:0] meas_value,
  // Detector state
  output var logic [1:0][1:0] det_type,
  output var logic [1:0] ch_avail,
  output var logic [1:0] ch_acquiring,
  output var logic [1:0][15:0] cal_point_nm,
  output var logic [1:0][3:0] gain_in_use
);
  initial begin
    meas_valid = 2'h0;
    meas_status = '1;
    meas_value = '1;
    det_type = '0;
    ch_avail = 2'h3;
    ch_acquiring = 2'h1;
    cal_point_nm = {16'h0320, 16'h0320};
    gain_in_use = {4'h9, 4'h9};
  end
  // Idle lines show inverted last value so stale data never looks valid
  task automatic offer(input int c, input logic [2:0] st, input logic [31:0] v);
    @(posedge hclk);
    meas_valid[c] <= 1'b1;
    meas_status[c] <= st;
    meas_value[c] <= v;
    @(posedge hclk);
    meas_valid[c] <= 1'b0;
    meas_status[c] <= ~st;
    meas_value[c] <= ~v;
    repeat (3) @(posedge hclk);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_meter_channel_settings_control.sv ====
// Register-level testbench of the settings block
`timescale 1ns/1ps
`default_nettype none
`include "mcs_consts.svh"
module tb_meter_channel_settings_control;
  logic hclk, hresetn, hsel, hwrite, trig_in;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, d;
  int fails, total_checks, i, n;
  wire logic [31:0] hrdata;
  wire logic hready, hreadyout, hresp, trig_pulse, trig_enable, trig_rising;
  wire logic front_panel_lockout, device_error;
  wire logic [1:0] analog_lpf_sel, auto_range, new_valid_data_flag;
  wire logic [1:0] meas_valid, ch_avail, ch_acquiring;
  wire logic [1:0][2:0] mode_sel, units_sel, meas_status;
  wire logic [1:0][1:0] ref_sel, det_type;
  wire logic [1:0][15:0] wavelength_nm, cal_point_nm;
  wire logic [1:0][3:0] manual_gain, gain_in_use;
  wire logic [1:0][31:0] meas_value;
  assign hready = hreadyout;
  mcs_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .trig_in, .trig_pulse, .meas_valid, .meas_status,
    .meas_value, .det_type, .ch_avail, .ch_acquiring, .cal_point_nm, .gain_in_use,
    .trig_enable, .trig_rising, .front_panel_lockout, .device_error, .analog_lpf_sel,
    .mode_sel, .units_sel, .ref_sel, .wavelength_nm, .manual_gain, .auto_range,
    .new_valid_data_flag);
  mcs_frontend_model fe (.hclk, .meas_valid, .meas_status, .meas_value, .det_type,
    .ch_avail, .ch_acquiring, .cal_point_nm, .gain_in_use);
  always #2.5 hclk = ~hclk;
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Holds address phase, then data phase, until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    #1;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask
  task automatic pulses(input logic v);
    @(posedge hclk);
    trig_in <= v;
    n = 0;
    repeat (10) begin
      @(posedge hclk);
      #1;
      if (trig_pulse === 1'b1) n++;
    end
  endtask
  function automatic logic [31:0] ca(input int c, input logic [1:0] r);
    ca = {24'h0, (c != 0) ? `MCS_OFF_CH_B : `MCS_OFF_CH_A, r, 2'b00};
  endfunction
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    summarize();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, trig_in, htrans, hsize, haddr, hwdata} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`MCS_OFF_CTRL, 32'h7, 32'h2);
    rc(`MCS_OFF_EVMASK, 32'hff, 32'h0);
    rc(ca(0, `MCS_CH_RANGE), 32'h10f, 32'h109);
    xfer(1'b1, `MCS_OFF_CTRL, 32'h7);
    chk({trig_enable, trig_rising, front_panel_lockout}, 32'h7);
    xfer(1'b1, `MCS_OFF_CTRL, 32'h0);
    rc(`MCS_OFF_CTRL, 32'h7, 32'h0);
    xfer(1'b1, `MCS_OFF_EVMASK, 32'h1a5);
    rc(`MCS_OFF_EVMASK, 32'hffffffff, 32'ha5);
    // Bit 0 enables, bit 1 picks the rising edge
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, `MCS_OFF_CTRL, i);
      pulses(1'b1);
      chk(n, i == 3);
      pulses(1'b0);
      chk(n, i == 1);
    end
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, ca(0, `MCS_CH_CFG), i);
      rc(ca(0, `MCS_CH_CFG), 32'h3, i);
      chk(analog_lpf_sel[0], i % 2);
    end
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h0);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h31);
    rc(ca(0, `MCS_CH_CFG), 32'h3, 32'h0);
    chk(device_error, 1);
    rc(`MCS_OFF_EVENT, 32'hff, 32'h1);
    chk(device_error, 0);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h1);
    fe.det_type[0] = 2'h2;
    rc(ca(0, `MCS_CH_CFG), 32'h3, 32'h0);
    fe.det_type[0] = 2'h0;
    fe.det_type[1] = 2'h1;
    xfer(1'b1, ca(1, `MCS_CH_CFG), 32'h3);
    rc(ca(1, `MCS_CH_CFG), 32'h3, 32'h0);
    xfer(1'b1, ca(1, `MCS_CH_CFG), 32'h2);
    rc(ca(1, `MCS_CH_CFG), 32'h3, 32'h2);
    rc(`MCS_OFF_EVENT, 32'hff, 32'h1);
    fe.det_type[1] = 2'h0;
    for (i = 0; i < 7; i++) begin
      xfer(1'b1, ca(0, `MCS_CH_CFG), i << 4);
      rc(ca(0, `MCS_CH_CFG), 32'h7070, (i << 4) | ((i inside {2, 5, 6}) ? 32'h4000 : 0));
    end
    chk({ref_sel[0], units_sel[0], mode_sel[0]}, 32'h26);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h4000);
    rc(ca(0, `MCS_CH_CFG), 32'h7070, 32'h0);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h70);
    rc(ca(0, `MCS_CH_CFG), 32'h70, 32'h0);
    rc(`MCS_OFF_EVENT, 32'hff, 32'h1);
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, ca(0, `MCS_CH_CFG), i << 8);
      rc(ca(0, `MCS_CH_CFG), 32'h300, i << 8);
    end
    fe.ch_avail[1] = 1'b0;
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h100);
    rc(ca(0, `MCS_CH_CFG), 32'h300, 32'h200);
    chk(ref_sel[0], 32'h2);
    chk(device_error, 0);
    rc(`MCS_OFF_EVENT, 32'hff, 32'h2);
    fe.ch_avail[1] = 1'b1;
    xfer(1'b1, ca(0, `MCS_CH_WAVE), 32'h514);
    chk(wavelength_nm[0], 32'h514);
    rc(ca(0, `MCS_CH_WAVE), 32'hffff, 32'h320);
    xfer(1'b1, ca(0, `MCS_CH_RANGE), 32'h5);
    chk({auto_range[0], manual_gain[0]}, 32'h5);
    rc(ca(0, `MCS_CH_RANGE), 32'h10f, 32'h9);
    xfer(1'b1, ca(0, `MCS_CH_RANGE), 32'h100);
    chk(auto_range[0], 1);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h0);
    fe.offer(0, 3'h0, 32'd100);
    rc(`MCS_OFF_STATUS, 32'h1, 32'h1);
    rc(ca(0, `MCS_CH_DATA), 32'hffffffff, 32'd100);
    rc(`MCS_OFF_STATUS, 32'h1, 32'h0);
    for (i = 1; i < 5; i++) fe.offer(0, 3'(i), 32'd999);
    rc(`MCS_OFF_STATUS, 32'h1, 32'h0);
    rc(ca(0, `MCS_CH_DATA), 32'hffffffff, 32'd100);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h2);
    for (i = 1; i < 13; i++) fe.offer(0, 3'h0, i * 10);
    rc(ca(0, `MCS_CH_DATA), 32'hffffffff, 32'd75);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h0);
    xfer(1'b1, ca(0, `MCS_CH_CFG), 32'h2);
    fe.offer(0, 3'h0, 32'd7);
    rc(ca(0, `MCS_CH_DATA), 32'hffffffff, 32'd7);
    fe.ch_acquiring = 2'h3;
    // A still averages: 7 held plus 9 gives 8
    fe.offer(0, 3'h0, 32'd9);
    fe.offer(1, 3'h0, 32'd6);
    rc(`MCS_OFF_STATUS, 32'h33, 32'h23);
    chk(new_valid_data_flag, 32'h3);
    rc(`MCS_OFF_PAIR0, 32'hffffffff, 32'd8);
    rc(`MCS_OFF_PAIR1, 32'hffffffff, 32'd6);
    rc(`MCS_OFF_STATUS, 32'h3, 32'h0);
    fe.ch_acquiring = 2'h1;
    rc(`MCS_OFF_STATUS, 32'h30, 32'h10);
    rc(32'h100, 32'hffffffff, 32'h0);
    chk(hresp, 32'h0);
    summarize();
  end
endmodule
bind mcs_top mcs_properties u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .trig_in, .trig_pulse, .trig_enable, .trig_rising, .meas_valid, .meas_status,
  .det_type, .mode_sel, .units_sel, .ref_sel, .analog_lpf_sel, .new_valid_data_flag);
`default_nettype wire
